// File: tb/fcs_engine_model.sv
`timescale 1ns/10ps
module fcs_engine_model #(
   parameter int DLY = 20
) (
   input wire logic clk_i, // system clock
   input wire logic rst_i, // sync reset
   input wire logic start_i, // command start
   input wire logic blank_val_i, // verify result to give
   output logic done_o, // done pulse
   output logic blank_o // verify result
);
   int cnt = 0;
   initial begin
      done_o = 1'b0;
      blank_o = 1'b0;
   end
   // result line keeps toggling outside the done cycle
   always @(posedge clk_i) begin
      done_o <= 1'b0;
      blank_o <= ~blank_o;
      if (rst_i) begin
         cnt <= 0;
      end else if (start_i) begin
         cnt <= DLY;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
         if (cnt == 1) begin
            done_o <= 1'b1;
            blank_o <= blank_val_i;
         end
      end
   end
endmodule : fcs_engine_model

// File: tb/fcs_top_tb.sv
`timescale 1ns/10ps
`include "fcs_cfg.svh"
`define TB_CHK(what, exp, got) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) begin \
         fails++; \
         $display("Error %s expected %0h seen %0h", what, exp, got); \
      end \
   end
module fcs_top_tb
   import fcs_pkg::*;
;
   logic clk_i, rst_i, cyc, stb, wr_en, blank_val, ack_o, scr, irq;
   logic start, done, blank;
   logic [1:0] strap;
   logic [7:0] adr, flags;
   logic [31:0] dat, dat_o;
   fcs_cmd_t cmd, last_cmd;
   int fails = 0;
   int n_compared = 0;
   int n_start = 0;

   fcs_top fcs_top_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .cyc_i(cyc), .stb_i(stb), .we_i(wr_en), .adr_i(adr),
      .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
      .latency_strap_i(strap), .single_cycle_read_o(scr), .irq_o(irq),
      .status_flag_outputs_o(flags), .exec_start_o(start),
      .exec_cmd_o(cmd), .exec_done_i(done), .exec_blank_i(blank));
   fcs_engine_model fcs_engine_model_inst (.clk_i(clk_i), .rst_i(rst_i),
      .start_i(start), .blank_val_i(blank_val), .done_o(done),
      .blank_o(blank));

   always @(posedge clk_i) begin
      if (start === 1'b1) begin
         n_start <= n_start + 1;
         last_cmd <= cmd;
      end
   end

   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_sim

   task automatic wb(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      wr_en <= w;
      adr <= a;
      dat <= d;
      // ack and read data are taken at the rising edge that sees ack high
      @(posedge clk_i);
      while (ack_o !== 1'b1 && n < 40) begin
         @(posedge clk_i);
         n++;
      end
      `TB_CHK("ack", 1'b1, ack_o);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      wb(1'b0, a, 32'h0, q);
   endtask : rd

   task automatic chk_stat(input logic [7:0] e);
      logic [31:0] q;
      rd(`FCS_OFF_STAT, q);
      `TB_CHK("status", {24'h0, e}, q);
      `TB_CHK("flag pins", e, flags);
   endtask : chk_stat

   // one software step each, launch last
   task automatic seq(input logic [7:0] c, input logic [31:0] a,
         input logic [31:0] d);
      wr(`FCS_OFF_AADR, a);
      wr(`FCS_OFF_ADAT, d);
      wr(`FCS_OFF_CMD, {24'h0, c});
      wr(`FCS_OFF_STAT, 32'h80);
   endtask : seq

   task automatic do_reset;
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask : do_reset

   task automatic t_reset;
      logic [31:0] q;
      chk_stat(8'hC0);
      `TB_CHK("irq off", 1'b0, irq);
      rd(`FCS_OFF_LAT, q);
      `TB_CHK("latency", 32'h2, q);
      wr(`FCS_OFF_LAT, 32'hFFFF);
      rd(`FCS_OFF_LAT, q);
      `TB_CHK("latency ro", 32'h2, q);
      `TB_CHK("single", 1'b1, scr);
      wr(`FCS_OFF_STAT, 32'h40);
      chk_stat(8'hC0);
      rd(8'h40, q);
      `TB_CHK("unmapped", 32'h0, q);
      // divider not yet written
      seq(8'h20, 32'h3000, 32'h1);
      repeat (5) @(posedge clk_i);
      `TB_CHK("no start", 0, n_start);
      chk_stat(8'hD0);
      wr(`FCS_OFF_STAT, 32'h10);
      chk_stat(8'hC0);
      wr(`FCS_OFF_DIV, 32'h13);
      wr(`FCS_OFF_PROT, 32'h0);
   endtask : t_reset

   task automatic t_cmds;
      logic [6:0] codes [5];
      logic [31:0] q;
      codes = '{`FCS_CMD_BLANK, `FCS_CMD_PVER, `FCS_CMD_PROG,
         `FCS_CMD_PERASE, `FCS_CMD_MERASE};
      wr(`FCS_OFF_MCR, 32'h40);
      for (int i = 0; i < 5; i++) begin
         blank_val <= i[0];
         seq({1'b0, codes[i]}, 32'h2000 + 4 * i, 32'hA5A50000 + i);
         repeat (3) @(posedge clk_i);
         chk_stat(i >= 2 ? 8'h84 : 8'h80);
         `TB_CHK("irq busy", 1'b0, irq);
         q = 0;
         for (int n = 0; n < 40 && q[6] !== 1'b1; n++) begin
            rd(`FCS_OFF_STAT, q);
         end
         chk_stat(i >= 1 ? 8'hC4 : 8'hC0);
         `TB_CHK("irq done", 1'b1, irq);
         `TB_CHK("starts", i + 1, n_start);
         `TB_CHK("code", codes[i], last_cmd.code);
         `TB_CHK("addr", 32'h2000 + 4 * i, last_cmd.addr);
         `TB_CHK("data", 32'hA5A50000 + i, last_cmd.data);
      end
      wr(`FCS_OFF_STAT, 32'h04);
      chk_stat(8'hC0);
      wr(`FCS_OFF_MCR, 32'h80);
      `TB_CHK("irq empty", 1'b1, irq);
      wr(`FCS_OFF_MCR, 32'h0);
      `TB_CHK("irq masked", 1'b0, irq);
   endtask : t_cmds

   task automatic t_errs;
      logic [31:0] q;
      int s;
      s = n_start;
      seq(8'hFF, 32'h2200, 32'h9);
      chk_stat(8'hD0);
      rd(`FCS_OFF_CMD, q);
      `TB_CHK("cmd reg", 32'h7F, q);
      wr(`FCS_OFF_STAT, 32'h10);
      chk_stat(8'hC0);
      wr(`FCS_OFF_AADR, 32'h2100);
      wr(`FCS_OFF_ADAT, 32'h5);
      wr(`FCS_OFF_STAT, 32'h00);
      chk_stat(8'hD0);
      wr(`FCS_OFF_STAT, 32'h10);
      wr(`FCS_OFF_PROT, 32'h2);
      seq(8'h20, 32'h1000, 32'h7);
      chk_stat(8'hE0);
      wr(`FCS_OFF_STAT, 32'h00);
      chk_stat(8'hE0);
      repeat (25) @(posedge clk_i);
      `TB_CHK("refused", s, n_start);
      wr(`FCS_OFF_STAT, 32'h20);
      chk_stat(8'hC0);
      wr(`FCS_OFF_PROT, 32'h0);
   endtask : t_errs

   task automatic t_strap;
      logic [31:0] q;
      strap <= 2'b01;
      do_reset();
      chk_stat(8'hC0);
      `TB_CHK("two cycle", 1'b0, scr);
      rd(`FCS_OFF_LAT, q);
      `TB_CHK("latency 01", 32'h1, q);
   endtask : t_strap

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   initial begin
      rst_i = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      wr_en = 1'b0;
      adr = 8'h00;
      dat = 32'h0;
      strap = 2'b10;
      blank_val = 1'b0;
      do_reset();
      t_reset();
      t_cmds();
      t_errs();
      t_strap();
      end_sim();
   end

   // whole run is a few hundred cycles
   initial begin
      #400000;
      fails++;
      end_sim();
   end
endmodule : fcs_top_tb

// File: verilog/fcs_cfg.svh
`ifndef FCS_CFG_SVH
`define FCS_CFG_SVH
// register byte offsets
`define FCS_OFF_MCR 8'h00
`define FCS_OFF_DIV 8'h04
`define FCS_OFF_PROT 8'h08
`define FCS_OFF_STAT 8'h0C
`define FCS_OFF_CMD 8'h10
`define FCS_OFF_LAT 8'h14
`define FCS_OFF_AADR 8'h18
`define FCS_OFF_ADAT 8'h1C
// status and control bit positions
`define FCS_BIT_BEF 7
`define FCS_BIT_CCF 6
`define FCS_BIT_PVF 5
`define FCS_BIT_AEF 4
`define FCS_BIT_BLF 2
`define FCS_BIT_BEIE 7
`define FCS_BIT_COMMAND_COMPLETE_IRQ_ENABLE 6
`define FCS_BIT_DIVLD 8
// command codes
`define FCS_CMD_BLANK 7'h05
`define FCS_CMD_PVER 7'h06
`define FCS_CMD_PROG 7'h20
`define FCS_CMD_PERASE 7'h40
`define FCS_CMD_MERASE 7'h41
// latency field
`define FCS_LAT_SINGLE 2'h2
`define FCS_LAT_RST 2'h0
// flag reset: buffer empty and complete set, errors and blank clear
`define FCS_FLG_RST 5'h18
// sector index taken from array address
`define FCS_SEC_HI 16
`define FCS_SEC_LO 12
`define FCS_SEL_ALL 4'hF
`endif

// File: verilog/fcs_pkg.sv
package fcs_pkg;
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_ADDR = 2'b01,
      SEQ_CMD = 2'b10
   } fcs_seq_t;

   typedef struct packed {
      logic [6:0] code;
      logic [31:0] addr;
      logic [31:0] data;
   } fcs_cmd_t;

   typedef struct packed {
      logic buffer_empty_flag;
      logic command_complete_flag;
      logic protection_violation_flag;
      logic access_error_flag;
      logic blank_flag;
   } fcs_flags_t;
endpackage : fcs_pkg

// File: verilog/fcs_top.sv
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "fcs_cfg.svh"
// Operation
// - buffer-empty flag sets when command buffers are empty
// - writing one to buffer-empty clears it and launches the command
// - writing zero to buffer-empty keeps it but aborts an open sequence
// - interrupt while buffer-empty flag and its enable are set
// - complete flag clears with launch, sets when all commands finish
// - software writes change the complete flag only by launching
// - interrupt while complete flag and its enable are set
// - protection flag sets on protected program or erase, write one clears
// - protection flag set refuses sequence start and launch
// - access error flag sets on illegal sequence, write one clears
// - access error flag set refuses sequence start and launch
// - blank flag sets when a verify finds all erased, write one clears
// - blank clear after finished verify means not erased
// - reserved status and latency bits read zero
// - command bits 6 to 0 read and write, bit 7 reads zero
// - unknown command code in a sequence sets access error
// - code 05 is blank check, 06 is page erase verify
// - code 20 programs, 40 erases a page, 41 erases all
// - latency field is factory set and read only
// - latency 2'b10 gives single-cycle reads, others two-cycle
// - five flags also drive status outputs at bits 7-4 and 2
// - a successful abort sets access error
// - no command runs until the divider has been written
module fcs_top
   import fcs_pkg::*;
(
   input wire logic clk_i, // system clock
   input wire logic rst_i, // sync reset
   input wire logic ce_i, // clock enable
   input wire logic cyc_i, // wishbone cycle
   input wire logic stb_i, // wishbone strobe
   input wire logic we_i, // write enable
   input wire logic [7:0] adr_i, // byte address
   input wire logic [3:0] sel_i, // byte lanes
   input wire logic [31:0] dat_i, // write data
   output logic [31:0] dat_o, // read data
   output logic ack_o, // acknowledge
   input wire logic [1:0] latency_strap_i, // factory latency pins
   output logic single_cycle_read_o, // one-cycle flash read
   output logic irq_o, // interrupt request
   output logic [7:0] status_flag_outputs_o, // flag copies
   output logic exec_start_o, // start pulse to engine
   output fcs_cmd_t exec_cmd_o, // command to engine
   input wire logic exec_done_i, // engine finished
   input wire logic exec_blank_i // verify found erased
);

   function automatic logic [31:0] merge_bytes(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge_bytes
   function automatic logic code_valid(input logic [6:0] c);
      return c == `FCS_CMD_BLANK || c == `FCS_CMD_PVER ||
         c == `FCS_CMD_PROG || c == `FCS_CMD_PERASE ||
         c == `FCS_CMD_MERASE;
   endfunction : code_valid
   function automatic logic is_verify(input logic [6:0] c);
      return c == `FCS_CMD_BLANK || c == `FCS_CMD_PVER;
   endfunction : is_verify
   // bus and register state
   logic ack_r, ack_nxt;
   logic [31:0] dat_r, dat_nxt;
   logic beie_r, beie_nxt, command_complete_irq_enable_r, command_complete_irq_enable_nxt;
   logic [7:0] div_r, div_nxt;
   logic divld_r, divld_nxt;
   logic [31:0] prot_r, prot_nxt;
   logic [6:0] cmd_r, cmd_nxt;
   logic [31:0] aadr_r, aadr_nxt;
   fcs_flags_t flg_r, flg_nxt;
   // sequence and execution state
   fcs_seq_t seq_r, seq_nxt;
   logic [31:0] sadr_r, sadr_nxt, sdat_r, sdat_nxt;
   fcs_cmd_t pend_r, pend_nxt, act_r, act_nxt;
   logic pendv_r, pendv_nxt, busy_r, busy_nxt;
   logic start_r, start_nxt;
   // latency strap
   logic [1:0] lat_s1_r, lat_s2_r, lat_r, lat_nxt, latv_r, latv_nxt;
   logic latcap_r, latcap_nxt;
   logic single_r, single_nxt;
   logic req, wr, wr_lo, hit_stat, launch, abort, errs;
   logic [7:0] offs;
   always_comb begin
      offs = {adr_i[7:2], 2'b00};
      req = ce_i & cyc_i & stb_i & ~ack_r;
      wr = req & we_i;
      wr_lo = wr & sel_i[0];
      errs = flg_r.access_error_flag | flg_r.protection_violation_flag;
      hit_stat = wr_lo & (offs == `FCS_OFF_STAT);
      // launch needs a complete sequence and no error pending
      launch = hit_stat & dat_i[`FCS_BIT_BEF] & (seq_r == SEQ_CMD) &
         flg_r.buffer_empty_flag & ~errs;
      abort = hit_stat & ~dat_i[`FCS_BIT_BEF] &
         (seq_r != SEQ_IDLE);
   end

   // register file, sequence and engine
   always_comb begin
      ack_nxt = req;
      dat_nxt = dat_r;
      beie_nxt = beie_r;
      command_complete_irq_enable_nxt = command_complete_irq_enable_r;
      div_nxt = div_r;
      divld_nxt = divld_r;
      prot_nxt = prot_r;
      cmd_nxt = cmd_r;
      aadr_nxt = aadr_r;
      flg_nxt = flg_r;
      seq_nxt = seq_r;
      sadr_nxt = sadr_r;
      sdat_nxt = sdat_r;
      pend_nxt = pend_r;
      pendv_nxt = pendv_r;
      act_nxt = act_r;
      busy_nxt = busy_r;
      start_nxt = 1'b0;
      // software clears, each bit written as one clears its flag unless the same cycle also sets it
      if (hit_stat && dat_i[`FCS_BIT_PVF]) begin
         flg_nxt.protection_violation_flag = 1'b0;
      end
      if (hit_stat && dat_i[`FCS_BIT_AEF]) begin
         flg_nxt.access_error_flag = 1'b0;
      end
      if (hit_stat && dat_i[`FCS_BIT_BLF]) begin
         flg_nxt.blank_flag = 1'b0;
      end
      if (abort) begin
         seq_nxt = SEQ_IDLE;
         flg_nxt.access_error_flag = 1'b1;
      end else if (hit_stat && dat_i[`FCS_BIT_BEF] && !launch &&
            seq_r == SEQ_ADDR && !errs) begin
         seq_nxt = SEQ_IDLE;
         flg_nxt.access_error_flag = 1'b1;
      end
      if (launch) begin
         pend_nxt = '{code: cmd_r, addr: sadr_r, data: sdat_r};
         pendv_nxt = 1'b1;
         seq_nxt = SEQ_IDLE;
      end
      if (wr) begin
         case (offs)
            `FCS_OFF_MCR: begin
               if (sel_i[0]) begin
                  beie_nxt = dat_i[`FCS_BIT_BEIE];
                  command_complete_irq_enable_nxt = dat_i[`FCS_BIT_COMMAND_COMPLETE_IRQ_ENABLE];
               end
            end
            `FCS_OFF_DIV: begin
               if (sel_i[0]) begin
                  div_nxt = dat_i[7:0];
                  divld_nxt = 1'b1;
               end
            end
            `FCS_OFF_PROT: prot_nxt = merge_bytes(prot_r, dat_i, sel_i);
            `FCS_OFF_AADR: aadr_nxt = merge_bytes(aadr_r, dat_i, sel_i);
            `FCS_OFF_ADAT: begin
               // array write opens or restarts a sequence
               if (!errs && flg_r.buffer_empty_flag) begin
                  if (sel_i != `FCS_SEL_ALL || !divld_r ||
                        seq_r == SEQ_CMD) begin
                     flg_nxt.access_error_flag = 1'b1;
                     seq_nxt = SEQ_IDLE;
                  end else begin
                     sadr_nxt = aadr_r;
                     sdat_nxt = dat_i;
                     seq_nxt = SEQ_ADDR;
                  end
               end
            end
            `FCS_OFF_CMD: begin
               if (sel_i[0]) begin
                  cmd_nxt = dat_i[6:0];
                  if (!errs && seq_r != SEQ_ADDR) begin
                     flg_nxt.access_error_flag = 1'b1;
                     seq_nxt = SEQ_IDLE;
                  end else if (seq_r == SEQ_ADDR) begin
                     if (!code_valid(dat_i[6:0])) begin
                        flg_nxt.access_error_flag = 1'b1;
                        seq_nxt = SEQ_IDLE;
                     end else if ((dat_i[6:0] == `FCS_CMD_MERASE &&
                           prot_r != 32'h0) ||
                           ((dat_i[6:0] == `FCS_CMD_PROG ||
                           dat_i[6:0] == `FCS_CMD_PERASE) &&
                           prot_r[sadr_r[`FCS_SEC_HI:`FCS_SEC_LO]])) begin
                        flg_nxt.protection_violation_flag = 1'b1;
                        seq_nxt = SEQ_IDLE;
                     end else begin
                        seq_nxt = SEQ_CMD;
                     end
                  end
               end
            end
            default: ;
         endcase
      end
      // dispatch and completion
      if (!busy_r && pendv_r && divld_r) begin
         act_nxt = pend_r;
         busy_nxt = 1'b1;
         pendv_nxt = 1'b0;
         start_nxt = 1'b1;
      end
      if (busy_r && exec_done_i) begin
         busy_nxt = 1'b0;
         if (is_verify(act_r.code) && exec_blank_i) begin
            flg_nxt.blank_flag = 1'b1;
         end
      end
      if (launch) begin
         flg_nxt.buffer_empty_flag = 1'b0;
         flg_nxt.command_complete_flag = 1'b0;
      end else begin
         if (!pendv_r) begin
            flg_nxt.buffer_empty_flag = 1'b1;
         end
         if (!pendv_r && !busy_r) begin
            flg_nxt.command_complete_flag = 1'b1;
         end
      end
      // read data
      if (req && !we_i) begin
         case (offs)
            `FCS_OFF_MCR: dat_nxt = {24'h0, beie_r, command_complete_irq_enable_r, 6'h00};
            `FCS_OFF_DIV: dat_nxt = {23'h0, divld_r, div_r};
            `FCS_OFF_PROT: dat_nxt = prot_r;
            `FCS_OFF_STAT: dat_nxt = {24'h0, flg_r.buffer_empty_flag,
               flg_r.command_complete_flag,
               flg_r.protection_violation_flag,
               flg_r.access_error_flag, 1'b0, flg_r.blank_flag,
               2'b00};
            `FCS_OFF_CMD: dat_nxt = {25'h0, cmd_r};
            `FCS_OFF_LAT: dat_nxt = {30'h0, lat_r};
            `FCS_OFF_AADR: dat_nxt = aadr_r;
            default: dat_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         dat_r <= 32'h0;
         beie_r <= 1'b0;
         command_complete_irq_enable_r <= 1'b0;
         div_r <= 8'h00;
         divld_r <= 1'b0;
         prot_r <= 32'h0;
         cmd_r <= 7'h00;
         aadr_r <= 32'h0;
         flg_r <= `FCS_FLG_RST;
         seq_r <= SEQ_IDLE;
         sadr_r <= 32'h0;
         sdat_r <= 32'h0;
         pend_r <= '0;
         pendv_r <= 1'b0;
         act_r <= '0;
         busy_r <= 1'b0;
         start_r <= 1'b0;
      end else if (ce_i) begin
         ack_r <= ack_nxt;
         dat_r <= dat_nxt;
         beie_r <= beie_nxt;
         command_complete_irq_enable_r <= command_complete_irq_enable_nxt;
         div_r <= div_nxt;
         divld_r <= divld_nxt;
         prot_r <= prot_nxt;
         cmd_r <= cmd_nxt;
         aadr_r <= aadr_nxt;
         flg_r <= flg_nxt;
         seq_r <= seq_nxt;
         sadr_r <= sadr_nxt;
         sdat_r <= sdat_nxt;
         pend_r <= pend_nxt;
         pendv_r <= pendv_nxt;
         act_r <= act_nxt;
         busy_r <= busy_nxt;
         start_r <= start_nxt;
      end
   end
   // latency strap caught once after reset release
   always_comb begin
      latv_nxt = {latv_r[0], 1'b1};
      // both stages must hold pin samples, not reset values, and agree
      latcap_nxt = latcap_r | (latv_r[1] & (lat_s2_r == lat_s1_r));
      lat_nxt = latcap_r ? lat_r : lat_s2_r;
      single_nxt = (lat_r == `FCS_LAT_SINGLE);
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lat_s1_r <= `FCS_LAT_RST;
         lat_s2_r <= `FCS_LAT_RST;
         lat_r <= `FCS_LAT_RST;
         latv_r <= 2'h0;
         latcap_r <= 1'b0;
         single_r <= 1'b0;
      end else if (ce_i) begin
         lat_s1_r <= latency_strap_i;
         lat_s2_r <= lat_s1_r;
         lat_r <= lat_nxt;
         latv_r <= latv_nxt;
         latcap_r <= latcap_nxt;
         single_r <= single_nxt;
      end
   end
   assign dat_o = dat_r;
   assign ack_o = ack_r;
   assign single_cycle_read_o = single_r;
   assign exec_start_o = start_r;
   assign exec_cmd_o = act_r;
   assign irq_o = (flg_r.buffer_empty_flag & beie_r) |
      (flg_r.command_complete_flag & command_complete_irq_enable_r);
   assign status_flag_outputs_o = {flg_r.buffer_empty_flag,
      flg_r.command_complete_flag, flg_r.protection_violation_flag,
      flg_r.access_error_flag, 1'b0, flg_r.blank_flag,
      2'b00};

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   a_launch_clears_bef: assert property (
      launch |=> !flg_r.buffer_empty_flag && pendv_r)
      else $error("launch did not clear buffer empty");
   a_launch_clears_ccf: assert property (
      launch |=> !flg_r.command_complete_flag)
      else $error("launch did not clear complete flag");
   a_abort_sets_err: assert property (
      abort |=> flg_r.access_error_flag && seq_r == SEQ_IDLE)
      else $error("abort did not set access error");
   a_bad_code_err: assert property (
      wr_lo && offs == `FCS_OFF_CMD && seq_r == SEQ_ADDR &&
      !code_valid(dat_i[6:0]) |=> flg_r.access_error_flag)
      else $error("unknown code did not set access error");
   a_ccf_sw_hold: assert property (
      ce_i && flg_r.command_complete_flag && !launch
      |=> flg_r.command_complete_flag)
      else $error("complete flag dropped without launch");
   a_err_refuse: assert property (
      ce_i && errs && seq_r == SEQ_IDLE |=> seq_r == SEQ_IDLE)
      else $error("sequence started while error set");
   a_no_div_run: assert property (
      !divld_r |-> !exec_start_o ##1 !busy_r || divld_r)
      else $error("command ran before divider write");
   a_blank_done: assert property (
      ce_i && busy_r && exec_done_i && is_verify(act_r.code) &&
      exec_blank_i |=> flg_r.blank_flag ##1 1'b1)
      else $error("blank flag missed after verify");
   a_irq_bef: assert property (
      flg_r.buffer_empty_flag && beie_r |-> irq_o)
      else $error("buffer empty interrupt missing");
   a_stat_rsv: assert property (
      req && !we_i && offs == `FCS_OFF_STAT
      |=> ack_o && dat_o[3] == 1'b0 && dat_o[1:0] == 2'b00)
      else $error("reserved status bits not zero");
   a_ack_pulse: assert property (
      ack_o && ce_i |=> !ack_o)
      else $error("ack held longer than one cycle");
endmodule : fcs_top
